// File: rtl/twe_pkg.sv
// Contract
// (R1) select rise, start bit one, opcode, address
// (R2) read is opcode 10, 9/8-bit address
// (R3) zero dummy bit precedes read data
// (R4) read data changes on shift clock rise
// (R5) sequential read, no further dummy bits
// (R6) enable is opcode 00, address 11xx
// (R7) power-up leaves programming disabled
// (R8) enable persists until disable
// (R9) disable is opcode 00, address 00xx
// (R10) erase sets word to ones immediately
// (R11) write programs after last data bit
// (R12) status after select low 250 ns
// (R13) no status once cycle has ended
// (R14) erase all is opcode 00, address 10xx
// (R15) write all is 00, 01xx plus data
// (R16) host clocks every don't-care address bit
// (R17) word width pin high means 16-bit words
// (R18) read works enabled or disabled
// (R19) select low floats output, drops instruction
// (R20) disabled erase/write leave memory unchanged
package twe_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_NS          = 5;
	localparam int SEL_LOW_NS      = 250;
	localparam int SEL_LOW_CYC     = (SEL_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROG_TIME_MS    = 5;
	localparam int PROG_CYC        = PROG_TIME_MS * 1000000 / CLK_NS;
	localparam int LINK_HALF_NS    = 250;
	localparam int LINK_HALF_CYC   = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int STATUS_VALID_NS = 250;
	localparam int STATUS_CYC      = (STATUS_VALID_NS + CLK_NS - 1) / CLK_NS;

	// ----------------------------------------------------------------
	// frame layout
	// ----------------------------------------------------------------
	localparam int   ADDR_X8   = 9;
	localparam int   ADDR_X16  = 8;
	localparam int   DATA_X8   = 8;
	localparam int   DATA_X16  = 16;
	localparam int   WORDS     = 256;
	localparam int   FRAME_W   = 28;
	localparam logic START_BIT = 1'b1;
	localparam logic DUMMY_BIT = 1'b0;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;

	localparam logic [1:0] OP_EXT        = 2'h0;
	localparam logic [1:0] OP_WRITE      = 2'h1;
	localparam logic [1:0] OP_READ       = 2'h2;
	localparam logic [1:0] OP_ERASE      = 2'h3;
	localparam logic [1:0] EXT_DIS       = 2'h0;
	localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
	localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
	localparam logic [1:0] EXT_EN        = 2'h3;

	typedef enum logic [2:0] {
		CMD_READ, CMD_WRITE, CMD_ERASE, CMD_EN, CMD_DIS, CMD_ERASE_ALL, CMD_WRITE_ALL
	} twe_cmd_t;

endpackage

// File: rtl/twe_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface twe_link_if;
	logic select;
	logic shift_clock;
	logic serial_in;
	logic serial_out;
	logic serial_out_oe_n;
	logic data_line;

	// floating output reads high, as through a pull-up
	assign data_line = serial_out_oe_n ? 1'b1 : serial_out;

	modport dev (
		input  select,
		input  shift_clock,
		input  serial_in,
		output serial_out,
		output serial_out_oe_n
	);
	modport host (
		output select,
		output shift_clock,
		output serial_in,
		input  data_line
	);
endinterface
`default_nettype wire

// File: rtl/twe_device.sv
`timescale 1ns/1ps
`default_nettype none
module twe_device #(
	parameter int PROG_CYC    = twe_pkg::PROG_CYC,
	parameter int SEL_LOW_CYC = twe_pkg::SEL_LOW_CYC
) (
	input  wire logic clock_i,
	input  wire logic sys_rst_i,
	input  wire logic word_width_select_i,
	twe_link_if.dev   link,
	output logic      prog_enabled_o,
	output logic      busy_o
);

	localparam int PCW = $clog2(PROG_CYC + 1);

	typedef enum logic [2:0] {
		TWE_IDLE, TWE_START, TWE_OPC, TWE_ADDR, TWE_DATA, TWE_READ, TWE_STATUS, TWE_IGNORE
	} twe_phase_t;

	typedef struct packed {
		logic [1:0]  sel_s;
		logic [1:0]  sclk_s;
		logic [1:0]  si_s;
		logic [1:0]  wws_s;
		logic        sclk_prev;
		logic        sel_prev;
		twe_phase_t  ph;
		logic [4:0]  cnt;
		logic [1:0]  opc;
		logic [8:0]  addr;
		logic [15:0] sh;
		logic        en;
		logic [PCW-1:0] prog_cnt;
		logic [8:0]  left;
		logic        all;
		logic [7:0]  paddr;
		logic [15:0] pdata;
		logic [1:0]  pbe;
		logic [7:0]  low_cnt;
		logic        dout;
		logic        oe_n;
	} twe_dev_t;

	twe_dev_t    s;
	twe_dev_t    next_s;
	logic [15:0] mem [twe_pkg::WORDS];

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// x8 bytes live in 16-bit rows: even address in the high half
	function automatic logic [15:0] read_word(input logic [8:0] a, input logic x16);
		logic [15:0] row;
		row = x16 ? mem[a[7:0]] : mem[a[8:1]];
		if (x16)
			return row;
		return {(a[0] ? row[7:0] : row[15:8]), 8'h00};
	endfunction

	function automatic twe_dev_t start_prog(input twe_dev_t st, input logic all,
			input logic [15:0] d, input logic x16);
		twe_dev_t r;
		r = st;
		if (st.en) begin // see R20
			r.prog_cnt = PCW'(PROG_CYC);
			r.all      = all;
			r.left     = all ? 9'(twe_pkg::WORDS) : 9'h001;
			r.paddr    = x16 ? st.addr[7:0] : st.addr[8:1];
			r.pdata    = x16 ? d : {d[7:0], d[7:0]};
			r.pbe      = (all || x16) ? 2'h3 : (st.addr[0] ? 2'h1 : 2'h2);
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic       sel;
	logic       sclk_rise;
	logic       bit_in;
	logic       x16;
	logic       busy;
	logic [4:0] alen;
	logic [4:0] wlen;
	logic [8:0] na;
	logic [8:0] inc;

	always_comb begin
		next_s = s;
		next_s.sel_s  = {s.sel_s[0], link.select};
		next_s.sclk_s = {s.sclk_s[0], link.shift_clock};
		next_s.si_s   = {s.si_s[0], link.serial_in};
		next_s.wws_s  = {s.wws_s[0], word_width_select_i};
		sel       = s.sel_s[1];
		bit_in    = s.si_s[1];
		x16       = s.wws_s[1]; // see R17
		sclk_rise = s.sclk_s[1] & ~s.sclk_prev;
		next_s.sclk_prev = s.sclk_s[1];
		next_s.sel_prev  = sel;
		busy = (s.prog_cnt != '0) || (s.left != 9'h000);
		alen = x16 ? 5'(twe_pkg::ADDR_X16) : 5'(twe_pkg::ADDR_X8);
		wlen = x16 ? 5'(twe_pkg::DATA_X16) : 5'(twe_pkg::DATA_X8);
		na   = {s.addr[7:0], bit_in};
		inc  = s.addr + 9'h001;
		if (x16)
			inc[8] = 1'b0;

		// self-timed cycle: the array rows are swept while the timer runs
		if (s.prog_cnt != '0)
			next_s.prog_cnt = s.prog_cnt - PCW'(1);
		if (s.left != 9'h000)
			next_s.left = s.left - 9'h001;

		if (!sel)
			next_s.low_cnt = (s.low_cnt < 8'(SEL_LOW_CYC)) ? s.low_cnt + 8'h01 : s.low_cnt;
		else
			next_s.low_cnt = 8'h00;

		if (!sel) begin
			next_s.ph   = TWE_IDLE; // see R19
			next_s.oe_n = 1'b1;
			next_s.cnt  = 5'h00;
		end else if (!s.sel_prev) begin
			// new frame; while busy only a status poll is answered
			if (!busy)
				next_s.ph = TWE_START; // see R1, R13
			else if (s.low_cnt >= 8'(SEL_LOW_CYC))
				next_s.ph = TWE_STATUS; // see R12
			else
				next_s.ph = TWE_IGNORE;
		end else if (s.ph == TWE_STATUS) begin
			next_s.oe_n = 1'b0;
			next_s.dout = ~busy; // see R12
		end else if (sclk_rise) begin
			unique case (s.ph)
				TWE_START: begin
					if (bit_in == twe_pkg::START_BIT) begin // see R1
						next_s.ph  = TWE_OPC;
						next_s.cnt = 5'h00;
					end
				end
				TWE_OPC: begin
					next_s.opc = {s.opc[0], bit_in};
					next_s.cnt = s.cnt + 5'h01;
					if (s.cnt == 5'h01) begin
						next_s.ph  = TWE_ADDR;
						next_s.cnt = 5'h00;
					end
				end
				TWE_ADDR: begin
					next_s.addr = na;
					next_s.cnt  = s.cnt + 5'h01;
					if (s.cnt == alen - 5'h01) begin // see R16
						next_s.cnt = 5'h00;
						next_s.ph  = TWE_IGNORE;
						unique case (s.opc)
							twe_pkg::OP_READ: begin // see R2, R18
								next_s.sh   = read_word(na, x16);
								next_s.dout = twe_pkg::DUMMY_BIT; // see R3
								next_s.oe_n = 1'b0;
								next_s.ph   = TWE_READ;
							end
							twe_pkg::OP_ERASE: begin
								next_s = start_prog(next_s, 1'b0, twe_pkg::ERASED_WORD, x16); // see R10
							end
							twe_pkg::OP_WRITE: begin
								next_s.ph = TWE_DATA;
							end
							default: begin
								unique case (x16 ? na[7:6] : na[8:7])
									twe_pkg::EXT_EN:   next_s.en = 1'b1; // see R6, R8
									twe_pkg::EXT_DIS:  next_s.en = 1'b0; // see R9
									twe_pkg::EXT_ERASE_ALL: begin
										next_s = start_prog(next_s, 1'b1, twe_pkg::ERASED_WORD, x16); // see R14
									end
									default:           next_s.ph = TWE_DATA; // see R15
								endcase
							end
						endcase
					end
				end
				TWE_DATA: begin
					next_s.sh  = {s.sh[14:0], bit_in};
					next_s.cnt = s.cnt + 5'h01;
					if (s.cnt == wlen - 5'h01) begin
						next_s.ph = TWE_IGNORE;
						// opcode 00 here can only be write-all
						next_s = start_prog(next_s, s.opc == twe_pkg::OP_EXT,
							{s.sh[14:0], bit_in}, x16); // see R11, R15
					end
				end
				TWE_READ: begin
					next_s.dout = s.sh[15]; // see R4
					next_s.sh   = {s.sh[14:0], 1'b0};
					next_s.cnt  = s.cnt + 5'h01;
					if (s.cnt == wlen - 5'h01) begin
						// roll straight into the next word, no dummy
						next_s.cnt  = 5'h00;
						next_s.addr = inc;
						next_s.sh   = read_word(inc, x16); // see R5
					end
				end
				default: begin
				end
			endcase
		end
		// a cycle that ends during the poll drives ready (one)
		if (!busy && s.ph == TWE_STATUS && sel && s.sel_prev)
			next_s.dout = 1'b1; // see R13
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			s      <= '0; // see R7
			s.oe_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// array has no reset: it stands for non-volatile contents
	always_ff @(posedge clock_i) begin
		if (!sys_rst_i && s.left != 9'h000) begin
			if (s.pbe[1])
				mem[s.all ? 8'(s.left - 9'h001) : s.paddr][15:8] <= s.pdata[15:8];
			if (s.pbe[0])
				mem[s.all ? 8'(s.left - 9'h001) : s.paddr][7:0] <= s.pdata[7:0];
		end
	end

	assign link.serial_out      = s.dout;
	assign link.serial_out_oe_n = s.oe_n;
	assign prog_enabled_o       = s.en;
	assign busy_o               = busy;

endmodule
`default_nettype wire

// File: rtl/twe_host.sv
`timescale 1ns/1ps
`default_nettype none
module twe_host #(
	parameter int HALF_CYC    = twe_pkg::LINK_HALF_CYC,
	parameter int SEL_LOW_CYC = twe_pkg::SEL_LOW_CYC,
	parameter int STATUS_CYC  = twe_pkg::STATUS_CYC
) (
	input  wire logic             clock_i,
	input  wire logic             sys_rst_i,
	input  wire logic             word_width_select_i,
	input  wire logic             cmd_valid_i,
	output logic                  cmd_ready_o,
	input  wire twe_pkg::twe_cmd_t cmd_op_i,
	input  wire logic [8:0]       cmd_addr_i,
	input  wire logic [15:0]      cmd_data_i,
	input  wire logic [8:0]       cmd_words_i,
	output logic                  rd_valid_o,
	input  wire logic             rd_ready_i,
	output logic [15:0]           rd_data_o,
	output logic                  done_o,
	twe_link_if.host              link
);

	typedef enum logic [3:0] {
		TWH_IDLE, TWH_SETUP, TWH_TX_LO, TWH_TX_HI, TWH_RX_LO, TWH_RX_HI,
		TWH_PUSH, TWH_LOW, TWH_POLL, TWH_GAP
	} twh_state_t;

	typedef struct packed {
		twh_state_t  st;
		logic [7:0]  tmr;
		logic [27:0] bits;
		logic [4:0]  nb;
		logic        rx;
		logic        prog;
		logic        x16;
		logic [8:0]  words;
		logic [15:0] sh;
		logic [4:0]  bc;
		logic [1:0]  do_s;
		logic        sel;
		logic        sclk;
		logic        si;
		logic [15:0] f0;
		logic [15:0] f1;
		logic        wp;
		logic        rp;
		logic [1:0]  fcnt;
		logic        done;
	} twh_t;

	twh_t s;
	twh_t next_s;

	logic [1:0] opc;
	logic [8:0] af;
	logic       has_data;
	logic [4:0] wlen;
	logic       push;
	logic       pop;

	always_comb begin
		next_s      = s;
		next_s.do_s = {s.do_s[0], link.data_line};
		next_s.done = 1'b0;
		if (s.tmr != 8'h00)
			next_s.tmr = s.tmr - 8'h01;
		wlen = s.x16 ? 5'(twe_pkg::DATA_X16) : 5'(twe_pkg::DATA_X8);

		// command encoding
		has_data = (cmd_op_i == twe_pkg::CMD_WRITE) || (cmd_op_i == twe_pkg::CMD_WRITE_ALL);
		af       = word_width_select_i ? {cmd_addr_i[7:0], 1'b0} : cmd_addr_i;
		unique case (cmd_op_i)
			twe_pkg::CMD_READ:  opc = twe_pkg::OP_READ;
			twe_pkg::CMD_WRITE: opc = twe_pkg::OP_WRITE;
			twe_pkg::CMD_ERASE: opc = twe_pkg::OP_ERASE;
			default:            opc = twe_pkg::OP_EXT;
		endcase
		unique case (cmd_op_i)
			twe_pkg::CMD_EN:        af = {twe_pkg::EXT_EN, 7'h00}; // see R6
			twe_pkg::CMD_DIS:       af = {twe_pkg::EXT_DIS, 7'h00}; // see R9
			twe_pkg::CMD_ERASE_ALL: af = {twe_pkg::EXT_ERASE_ALL, 7'h00}; // see R14
			twe_pkg::CMD_WRITE_ALL: af = {twe_pkg::EXT_WRITE_ALL, 7'h00}; // see R15
			default: begin
			end
		endcase

		// two-entry read buffer
		push = 1'b0;
		pop  = (s.fcnt != 2'h0) && rd_ready_i;

		unique case (s.st)
			TWH_IDLE: begin
				if (cmd_valid_i) begin
					next_s.x16  = word_width_select_i;
					next_s.rx   = (cmd_op_i == twe_pkg::CMD_READ);
					next_s.prog = !(cmd_op_i inside {twe_pkg::CMD_READ, twe_pkg::CMD_EN,
						twe_pkg::CMD_DIS});
					next_s.words = (cmd_words_i == 9'h000) ? 9'h001 : cmd_words_i;
					// full address width always sent, don't-cares included
					if (word_width_select_i) begin
						next_s.bits = {twe_pkg::START_BIT, opc, af[8:1], cmd_data_i, 1'b0};
						next_s.nb   = 5'(3 + twe_pkg::ADDR_X16)
							+ (has_data ? 5'(twe_pkg::DATA_X16) : 5'h00); // see R16
					end else begin
						next_s.bits = {twe_pkg::START_BIT, opc, af, cmd_data_i[7:0], 8'h00};
						next_s.nb   = 5'(3 + twe_pkg::ADDR_X8)
							+ (has_data ? 5'(twe_pkg::DATA_X8) : 5'h00);
					end
					next_s.sel = 1'b1; // see R1
					next_s.tmr = 8'(HALF_CYC);
					next_s.st  = TWH_SETUP;
				end
			end
			TWH_SETUP: begin
				if (s.tmr == 8'h00) begin
					next_s.si  = s.bits[27];
					next_s.tmr = 8'(HALF_CYC);
					next_s.st  = TWH_TX_LO;
				end
			end
			TWH_TX_LO, TWH_RX_LO: begin
				if (s.tmr == 8'h00) begin
					next_s.sclk = 1'b1;
					next_s.tmr = 8'(HALF_CYC);
					next_s.st  = (s.st == TWH_TX_LO) ? TWH_TX_HI : TWH_RX_HI;
				end
			end
			TWH_TX_HI: begin
				if (s.tmr == 8'h00) begin
					next_s.sclk = 1'b0;
					next_s.bits = {s.bits[26:0], 1'b0};
					next_s.nb   = s.nb - 5'h01;
					next_s.si   = s.bits[26];
					next_s.tmr  = 8'(HALF_CYC);
					next_s.st   = TWH_TX_LO;
					if (s.nb == 5'h01) begin
						next_s.bc = 5'h00;
						if (s.rx) begin
							next_s.st = TWH_RX_LO;
						end else begin
							next_s.sel = 1'b0;
							next_s.tmr = 8'(SEL_LOW_CYC + 2);
							next_s.st  = s.prog ? TWH_LOW : TWH_GAP;
						end
					end
				end
			end
			TWH_RX_HI: begin
				// sampled late in the high half, after the rising-edge change
				if (s.tmr == 8'h00) begin
					next_s.sclk = 1'b0;
					next_s.sh = {s.sh[14:0], s.do_s[1]}; // see R3, R5
					next_s.bc = s.bc + 5'h01;
					next_s.tmr = 8'(HALF_CYC);
					next_s.st = (s.bc == wlen - 5'h01) ? TWH_PUSH : TWH_RX_LO;
				end
			end
			TWH_PUSH: begin
				// shift clock held low here: a full buffer stalls the link
				if (s.fcnt != 2'h2 || pop) begin
					push         = 1'b1;
					next_s.words = s.words - 9'h001;
					next_s.bc    = 5'h00;
					next_s.tmr   = 8'(HALF_CYC);
					next_s.st    = TWH_RX_LO;
					if (s.words == 9'h001) begin
						next_s.sel = 1'b0;
						next_s.tmr = 8'(SEL_LOW_CYC + 2);
						next_s.st  = TWH_GAP;
					end
				end
			end
			TWH_LOW: begin
				if (s.tmr == 8'h00) begin
					next_s.sel = 1'b1; // see R12
					next_s.tmr = 8'(STATUS_CYC);
					next_s.st  = TWH_POLL;
				end
			end
			TWH_POLL: begin
				// floating output reads high, so an ended cycle also exits
				if (s.tmr == 8'h00 && s.do_s[1]) begin // see R13
					next_s.sel = 1'b0;
					next_s.tmr = 8'(SEL_LOW_CYC + 2);
					next_s.st  = TWH_GAP;
				end
			end
			default: begin
				if (s.tmr == 8'h00) begin
					next_s.done = 1'b1;
					next_s.st   = TWH_IDLE;
				end
			end
		endcase

		if (push) begin
			if (s.wp)
				next_s.f1 = s.x16 ? s.sh : {8'h00, s.sh[7:0]};
			else
				next_s.f0 = s.x16 ? s.sh : {8'h00, s.sh[7:0]};
			next_s.wp = ~s.wp;
		end
		if (pop)
			next_s.rp = ~s.rp;
		next_s.fcnt = s.fcnt + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign cmd_ready_o      = (s.st == TWH_IDLE);
	assign rd_valid_o       = (s.fcnt != 2'h0);
	assign rd_data_o        = s.rp ? s.f1 : s.f0;
	assign done_o           = s.done;
	assign link.select      = s.sel;
	assign link.shift_clock = s.sclk;
	assign link.serial_in   = s.si;

endmodule
`default_nettype wire

// File: sim/twe_checker.sv
`timescale 1ns/1ps
`default_nettype none
module twe_checker (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic select,
	input wire logic shift_clock,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe_n,
	input wire logic data_line
);
	// ------------------------------------------------------------
	// frame tracking
	// ------------------------------------------------------------
	logic       sclk_q;
	logic [5:0] n_rise;
	logic [4:0] hdr;
	logic [3:0] since_rise;
	logic       rise;
	logic       data_fr;

	assign rise    = shift_clock & ~sclk_q;
	// write and write-all frames carry a data word
	assign data_fr = (hdr[3:2] == 2'h1) || (hdr[3:0] == 4'h1);

	always_ff @(posedge clock_i) begin
		if (sys_rst_i || !select) begin
			n_rise <= 6'h00;
			hdr    <= 5'h00;
		end else if (rise) begin
			if (n_rise != 6'h3F)
				n_rise <= n_rise + 6'h01;
			if (n_rise < 6'h05)
				hdr <= {hdr[3:0], serial_in};
		end
		sclk_q     <= sys_rst_i ? 1'b0 : shift_clock;
		since_rise <= (sys_rst_i || rise) ? 4'h0 : since_rise + {3'h0, since_rise != 4'hF};
	end

	// ------------------------------------------------------------
	// link properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_first_rise;
		rise && select && n_rise == 6'h00;
	endsequence
	sequence s_deselected;
		!select [*6];
	endsequence

	a_select_clock_low: assert property ($rose(select) |-> !shift_clock)
		else $error("select rose with shift clock high");
	a_start_bit_first: assert property (s_first_rise |-> serial_in)
		else $error("first bit of frame is not one");
	a_data_held_high: assert property (shift_clock && $past(shift_clock) |-> $stable(serial_in))
		else $error("serial input moved while shift clock high");
	a_frame_bit_count: assert property ($fell(select) && n_rise != 6'h00 && hdr[3:2] != 2'h2
		|-> (data_fr ? (n_rise == 6'h14 || n_rise == 6'h1B) : (n_rise == 6'h0B || n_rise == 6'h0C)))
		else $error("frame length wrong");
	a_dummy_zero: assert property ($fell(serial_out_oe_n) && n_rise != 6'h00 |-> !serial_out)
		else $error("read output did not start with zero");
	a_out_after_rise: assert property (!serial_out_oe_n && !$past(serial_out_oe_n)
		&& $changed(serial_out) && n_rise != 6'h00 |-> since_rise < 4'h8)
		else $error("read output changed away from a shift clock rise");
	a_status_ready_holds: assert property (select && $past(select) && n_rise == 6'h00
		&& $past(data_line) && !$past(serial_out_oe_n) |-> data_line)
		else $error("status went back to busy");
	a_float_deselect: assert property (s_deselected |-> serial_out_oe_n)
		else $error("output driven while deselected");
endmodule
`default_nettype wire

// File: sim/three_wire_eeprom_interface_test.sv
`timescale 1ns/1ps
`default_nettype none
module three_wire_eeprom_interface_test;
	localparam int LIMIT = 90000;
	logic              clock_i   = 1'b0;
	logic              sys_rst_i = 1'b1;
	logic              wws       = 1'b1;
	logic              cmd_valid = 1'b0;
	twe_pkg::twe_cmd_t cmd_op    = twe_pkg::CMD_READ;
	logic [8:0]        cmd_addr  = 9'h000;
	logic [15:0]       cmd_data  = 16'h0000;
	logic [8:0]        cmd_words = 9'h001;
	logic              rd_ready  = 1'b0;
	logic              hold      = 1'b0;
	logic              en        = 1'b0;
	logic              cmd_ready, rd_valid, done, prog_en, busy;
	logic [15:0]       rd_data;
	logic [15:0]       refm [512];
	logic [15:0]       got [$];
	int                n_mismatch = 0;
	int                n_compared = 0;
	int                cycles     = 0;
	int                seed       = 32'h5CAA;

	twe_link_if link_bus ();
	twe_device #(.PROG_CYC(600)) u_twe_device (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .word_width_select_i(wws),
		.link(link_bus.dev), .prog_enabled_o(prog_en), .busy_o(busy)
	);
	twe_host #(.HALF_CYC(8)) u_twe_host (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .word_width_select_i(wws),
		.cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op),
		.cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .cmd_words_i(cmd_words),
		.rd_valid_o(rd_valid), .rd_ready_i(rd_ready), .rd_data_o(rd_data),
		.done_o(done), .link(link_bus.host)
	);
	twe_checker u_twe_checker (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .select(link_bus.select),
		.shift_clock(link_bus.shift_clock), .serial_in(link_bus.serial_in),
		.serial_out(link_bus.serial_out), .serial_out_oe_n(link_bus.serial_out_oe_n),
		.data_line(link_bus.data_line)
	);

	always #2.5 clock_i = ~clock_i;

	// ------------------------------------------------------------
	// read sink and watchdog
	// ------------------------------------------------------------
	always @(negedge clock_i) begin
		rd_ready <= !hold && (($random(seed) & 3) != 0);
	end

	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (rd_valid && rd_ready)
			got.push_back(rd_data);
		if (cycles == LIMIT) begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// byte organisation keeps only the low half
	function automatic logic [15:0] msk(input logic [15:0] v);
		return wws ? v : {8'h00, v[7:0]};
	endfunction

	function automatic int nw();
		return wws ? 256 : 512;
	endfunction

	task automatic run(input twe_pkg::twe_cmd_t op, input logic [8:0] a,
			input logic [15:0] dt, input logic [8:0] n);
		int k;
		got.delete();
		@(negedge clock_i);
		cmd_op = op;
		cmd_addr = a;
		cmd_data = dt;
		cmd_words = n;
		cmd_valid = 1'b1;
		@(negedge clock_i);
		cmd_valid = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 20000) begin
			@(negedge clock_i);
			k++;
		end
		chk({15'h0000, cmd_ready}, 16'h0001);
		if (en) case (op)
			twe_pkg::CMD_WRITE: refm[a % nw()] = msk(dt);
			twe_pkg::CMD_ERASE: refm[a % nw()] = msk(16'hFFFF);
			twe_pkg::CMD_ERASE_ALL: foreach (refm[i]) refm[i] = msk(16'hFFFF);
			twe_pkg::CMD_WRITE_ALL: foreach (refm[i]) refm[i] = msk(dt);
			default: ;
		endcase
		if (op == twe_pkg::CMD_EN)
			en = 1'b1;
		if (op == twe_pkg::CMD_DIS)
			en = 1'b0;
		chk({15'h0000, prog_en}, {15'h0000, en});
		chk({15'h0000, busy}, 16'h0000);
		if (op == twe_pkg::CMD_READ) begin
			k = 0;
			while (got.size() < n && k < 2000) begin
				@(negedge clock_i);
				k++;
			end
			chk(16'(got.size()), 16'(n));
			for (int i = 0; i < n; i++)
				chk(got.size() > i ? got[i] : 16'hXXXX, refm[(a + i) % nw()]);
		end
	endtask

	// ------------------------------------------------------------
	// main sequence, word organisation then byte organisation
	// ------------------------------------------------------------
	initial begin
		logic [8:0]  a;
		logic [15:0] d;
		for (int w = 0; w < 2; w++) begin
			wws = (w == 0);
			sys_rst_i = 1'b1;
			en = 1'b0;
			repeat (6) @(negedge clock_i);
			sys_rst_i = 1'b0;
			chk({15'h0000, prog_en}, 16'h0000);
			run(twe_pkg::CMD_WRITE, 9'h003, 16'h5A5A, 9'h001);
			run(twe_pkg::CMD_EN, 9'h000, 16'h0000, 9'h001);
			run(twe_pkg::CMD_ERASE_ALL, 9'h000, 16'h0000, 9'h001);
			run(twe_pkg::CMD_DIS, 9'h000, 16'h0000, 9'h001);
			run(twe_pkg::CMD_WRITE, 9'h003, 16'h5A5A, 9'h001);
			run(twe_pkg::CMD_ERASE, 9'h004, 16'h0000, 9'h001);
			run(twe_pkg::CMD_WRITE_ALL, 9'h000, 16'h0000, 9'h001);
			run(twe_pkg::CMD_READ, 9'h002, 16'h0000, 9'h003);
			run(twe_pkg::CMD_EN, 9'h000, 16'h0000, 9'h001);
			repeat (8) begin
				a = 9'($random(seed));
				d = 16'($random(seed));
				run(d[1:0] == 2'h0 ? twe_pkg::CMD_ERASE : twe_pkg::CMD_WRITE, a, d, 9'h001);
				run(twe_pkg::CMD_READ, a - 9'h001, 16'h0000, 9'(($random(seed) & 3) + 1));
			end
			a = 9'(nw() - 1);
			run(twe_pkg::CMD_WRITE, a, 16'hC3A5, 9'h001);
			// 300-cycle sink stall, over before the first read word is pushed
			hold = 1'b1;
			fork
				begin
					repeat (300) @(negedge clock_i);
					hold = 1'b0;
				end
			join_none
			run(twe_pkg::CMD_READ, a, 16'h0000, 9'h004);
			run(twe_pkg::CMD_WRITE_ALL, 9'h000, 16'($random(seed)), 9'h001);
			run(twe_pkg::CMD_READ, 9'h0FE, 16'h0000, 9'h004);
			run(twe_pkg::CMD_DIS, 9'h000, 16'h0000, 9'h001);
		end
		conclude();
	end
endmodule
`default_nettype wire
